// [verilog/lpr_pkg.sv]
/*
  constants, field layout, timing and state types of the light/proximity readout.
  assumes a 100 MHz core clock and a two-wire serial bus master outside the device.
*/
package lpr_pkg;
  // register offsets
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_INT = 4'h2;
  localparam logic [3:0] REG_PLT = 4'h3;
  localparam logic [3:0] REG_PHT = 4'h4;
  localparam logic [3:0] REG_ALT = 4'h5;
  localparam logic [3:0] REG_ATS = 4'h6;
  localparam logic [3:0] REG_AHU = 4'h7;
  localparam logic [3:0] REG_PRES = 4'h8;
  localparam logic [3:0] REG_ARL = 4'h9;
  localparam logic [3:0] REG_ARH = 4'hA;
  localparam logic [3:0] REG_T1 = 4'hE;
  localparam logic [3:0] REG_T2 = 4'hF;
  // field positions
  localparam int CFG_PEN = 7;
  localparam int CFG_SLP = 4;
  localparam int CFG_DRV = 3;
  localparam int CFG_AEN = 2;
  localparam int CFG_RNG = 1;
  localparam int CFG_IRM = 0;
  localparam int INT_PFLAG = 7;
  localparam int INT_PPRST = 5;
  localparam int INT_AFLAG = 3;
  localparam int INT_APRST = 1;
  localparam int INT_AND = 0;
  // reset values and address
  localparam logic [7:0] RST_PHT = 8'hFF;
  localparam logic [7:0] RST_ATS = 8'hF0; // high threshold low nibble all ones, low threshold top nibble zero
  localparam logic [7:0] RST_AHU = 8'hFF;
  localparam logic [5:0] ADDR_HI = 6'h22;
  // timing
  localparam int CLK_NS = 10;
  localparam int ALS_PERIOD_US = 100000;
  localparam int PROX_CONV_US = 540;
  localparam int LED_ON_US = 100;
  localparam int SLEEP_UNIT_US = 12500;
  localparam logic [31:0] ALS_PERIOD_CYC = 32'(ALS_PERIOD_US * 1000 / CLK_NS);
  localparam logic [31:0] PROX_CONV_CYC = 32'(PROX_CONV_US * 1000 / CLK_NS);
  localparam logic [31:0] LED_ON_CYC = 32'(LED_ON_US * 1000 / CLK_NS);
  localparam logic [31:0] SLEEP_UNIT_CYC = 32'(SLEEP_UNIT_US * 1000 / CLK_NS);

  typedef enum logic [4:0] {I_IDLE = 5'h01, I_RX = 5'h02, I_ACK = 5'h04, I_TX = 5'h08,
                            I_MACK = 5'h10} lpr_i2c_e;
  typedef enum logic [3:0] {P_OFF = 4'h1, P_LED = 4'h2, P_CONV = 4'h4, P_SLEEP = 4'h8} lpr_prox_e;

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3, ad1, ad2;
    logic [7:0] ir1, ir2;
    logic [11:0] av1, av2, ai1, ai2;
    lpr_i2c_e st;
    logic [3:0] bits;
    logic [1:0] bidx;
    logic rd;
    logic [7:0] sh;
    logic [3:0] ptr;
    logic [7:0] cfg, intc, plt, pht, alt, ats, ahu, pres, t1, t2;
    logic [11:0] ares;
    logic [31:0] atim, ptim;
    logic [4:0] acnt, phc, plc;
    lpr_prox_e pst;
    logic [6:0] units;
    logic [7:0] pre, post;
    logic led, led_hi, sda_oe, sda_o, int_n;
  } lpr_state_s;

  // trips needed for a persistence code
  function automatic logic [4:0] lpr_need(input logic [1:0] c);
    unique case (c)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  // saturating trip counter step
  function automatic logic [4:0] lpr_inc(input logic [4:0] c);
    return (c == 5'h10) ? c : c + 5'h01;
  endfunction

  // sleep length in 12.5 ms units
  function automatic logic [6:0] lpr_slp(input logic [2:0] c);
    unique case (c)
      3'h7: return 7'h00;
      3'h6: return 7'h01;
      3'h5: return 7'h04;
      3'h4: return 7'h06;
      3'h3: return 7'h08;
      3'h2: return 7'h10;
      3'h1: return 7'h20;
      default: return 7'h40;
    endcase
  endfunction
endpackage

// [verilog/lpr_top.sv]
/*
  light/proximity readout: serial register port, both converters, thresholds, interrupt pin.
  assumes analog front ends deliver codes as levels; all pins come from outside the clock domain.
*/
`timescale 1ns/1ps
module lpr_top #(
  parameter logic [31:0] ALS_PERIOD = lpr_pkg::ALS_PERIOD_CYC,
  parameter logic [31:0] PROX_CONV = lpr_pkg::PROX_CONV_CYC,
  parameter logic [31:0] LED_ON = lpr_pkg::LED_ON_CYC,
  parameter logic [31:0] SLEEP_UNIT = lpr_pkg::SLEEP_UNIT_CYC
) (
  input wire logic core_clk, // 100 MHz
  input wire logic reset_n, // async, active low
  input wire logic scl_i, // bus clock level
  input wire logic sda_i, // bus data level
  output logic sda_o, // data drive value, always low
  output logic sda_oe, // high while pulling data low
  input wire logic address_select_pin, // address bit 0
  input wire logic [11:0] als_visible_code, // visible front-end code
  input wire logic [11:0] als_ir_code, // infrared front-end code
  input wire logic [7:0] prox_ir_level, // proximity ir level
  output logic int_n, // interrupt, active low
  output logic led_sink_pin, // led current sink on
  output logic led_drive_strength, // 1 = high amplitude
  output logic ambient_range_select // range to front end
);
  import lpr_pkg::*;

  lpr_state_s r, n;
  logic rise, fall, start, stop, wr, normal, atrip, aevt, pstore, pset;
  logic [11:0] acode, alo, ahi;
  logic [7:0] pdiff;

  // register read mux
  function automatic logic [7:0] rdata(input lpr_state_s s, input logic [3:0] a);
    unique case (a)
      REG_CFG: return s.cfg;
      REG_INT: return s.intc;
      REG_PLT: return s.plt;
      REG_PHT: return s.pht;
      REG_ALT: return s.alt;
      REG_ATS: return s.ats;
      REG_AHU: return s.ahu;
      REG_PRES: return s.pres;
      REG_ARL: return s.ares[7:0];
      REG_ARH: return {4'h0, s.ares[11:8]};
      REG_T1: return s.t1;
      REG_T2: return s.t2;
      default: return 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    // two-stage synchronisers, third stage only for bus edge detection
    n.scl1 = scl_i;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = sda_i;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    n.ad1 = address_select_pin;
    n.ad2 = r.ad1;
    n.ir1 = prox_ir_level;
    n.ir2 = r.ir1;
    n.av1 = als_visible_code;
    n.av2 = r.av1;
    n.ai1 = als_ir_code;
    n.ai2 = r.ai1;
    rise = r.scl2 & ~r.scl3;
    fall = ~r.scl2 & r.scl3;
    start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
    stop = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
    wr = 1'b0;
    // bus slave
    if (start) begin
      n.st = I_RX;
      n.bits = 4'h0;
      n.bidx = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = I_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        I_IDLE: ;
        I_RX: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.bits = r.bits + 4'h1;
          end else if (fall && r.bits == 4'h8) begin
            n.bits = 4'h0;
            n.bidx = (r.bidx == 2'h2) ? r.bidx : r.bidx + 2'h1;
            if (r.bidx == 2'h0) begin
              if (r.sh[7:1] == {ADDR_HI, r.ad2}) begin
                n.sda_oe = 1'b1;
                n.rd = r.sh[0];
                n.st = I_ACK;
              end else begin
                n.st = I_IDLE;
              end
            end else begin
              n.sda_oe = 1'b1;
              n.st = I_ACK;
              n.rd = 1'b0;
              if (r.bidx == 2'h1) begin
                n.ptr = r.sh[3:0];
              end else begin
                wr = 1'b1;
                n.ptr = r.ptr + 4'h1;
              end
            end
          end
        end
        I_ACK: begin
          if (fall) begin
            if (r.rd) begin
              n.st = I_TX;
              n.sh = rdata(r, r.ptr);
              n.sda_oe = ~n.sh[7];
              n.bits = 4'h1;
              n.ptr = r.ptr + 4'h1;
            end else begin
              n.sda_oe = 1'b0;
              n.st = I_RX;
            end
          end
        end
        I_TX: begin
          if (fall) begin
            if (r.bits == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st = I_MACK;
            end else begin
              n.sda_oe = ~r.sh[6];
              n.sh = {r.sh[6:0], 1'b0};
              n.bits = r.bits + 4'h1;
            end
          end
        end
        I_MACK: begin
          if (rise) begin
            n.st = r.sda2 ? I_IDLE : I_ACK;
          end
        end
      endcase
    end
    // register writes; a written zero clears a flag, a written one keeps it
    if (wr) begin
      unique case (r.ptr)
        REG_CFG: n.cfg = r.sh;
        REG_INT: n.intc = {r.intc[INT_PFLAG] & r.sh[INT_PFLAG], r.sh[6:5], 1'b0,
                           r.intc[INT_AFLAG] & r.sh[INT_AFLAG], r.sh[2:0]};
        REG_PLT: n.plt = r.sh;
        REG_PHT: n.pht = r.sh;
        REG_ALT: n.alt = r.sh;
        REG_ATS: n.ats = r.sh;
        REG_AHU: n.ahu = r.sh;
        REG_T1: n.t1 = r.sh;
        REG_T2: n.t2 = r.sh;
        default: ;
      endcase
    end
    normal = (r.t1 == 8'h00) && (r.t2 == 8'h00);
    // ambient channel, free running on its own timer
    acode = r.cfg[CFG_IRM] ? r.ai2 : r.av2;
    alo = {r.ats[3:0], r.alt};
    ahi = {r.ahu, r.ats[7:4]};
    atrip = (acode < alo) || (acode > ahi);
    aevt = r.cfg[CFG_AEN] && normal && r.atim == ALS_PERIOD - 32'h1;
    if (!(r.cfg[CFG_AEN] && normal)) begin
      n.atim = 32'h0;
      n.acnt = 5'h00;
    end else if (aevt) begin
      n.atim = 32'h0;
      n.ares = acode;
      n.acnt = atrip ? lpr_inc(r.acnt) : 5'h00;
      if (atrip && lpr_inc(r.acnt) >= lpr_need(r.intc[INT_APRST +: 2])) begin
        n.intc[INT_AFLAG] = 1'b1;
      end
    end else begin
      n.atim = r.atim + 32'h1;
    end
    // proximity channel
    pdiff = (r.post > r.pre) ? r.post - r.pre : 8'h00;
    pstore = 1'b0;
    pset = 1'b0;
    if (!(r.cfg[CFG_PEN] && normal)) begin
      n.pst = P_OFF;
      n.led = 1'b0;
      n.ptim = 32'h0;
      n.phc = 5'h00;
      n.plc = 5'h00;
    end else begin
      unique case (r.pst)
        P_OFF: begin
          n.pst = P_LED;
          n.pre = r.ir2;
          n.led = 1'b1;
          n.led_hi = r.cfg[CFG_DRV];
          n.ptim = 32'h1;
        end
        P_LED: begin
          n.ptim = r.ptim + 32'h1;
          if (r.ptim == LED_ON) begin
            n.led = 1'b0;
            n.post = r.ir2;
            n.pst = P_CONV;
          end
        end
        P_CONV: begin
          n.ptim = r.ptim + 32'h1;
          if (r.ptim == PROX_CONV - 32'h1) begin
            pstore = 1'b1;
            n.pres = pdiff;
            n.pst = P_SLEEP;
            n.ptim = 32'h0;
            n.units = lpr_slp(r.cfg[CFG_SLP +: 3]);
            n.phc = (pdiff > r.pht) ? lpr_inc(r.phc) : 5'h00;
            n.plc = (pdiff < r.plt) ? lpr_inc(r.plc) : 5'h00;
            if (pdiff < r.plt && lpr_inc(r.plc) >= lpr_need(r.intc[INT_PPRST +: 2])) begin
              n.intc[INT_PFLAG] = 1'b0;
            end
            if (pdiff > r.pht && lpr_inc(r.phc) >= lpr_need(r.intc[INT_PPRST +: 2])) begin
              pset = 1'b1;
              n.intc[INT_PFLAG] = 1'b1;
            end
          end
        end
        P_SLEEP: begin
          if (r.units == 7'h00) begin
            n.pst = P_OFF;
          end else if (r.ptim == SLEEP_UNIT - 32'h1) begin
            n.ptim = 32'h0;
            n.units = r.units - 7'h01;
          end else begin
            n.ptim = r.ptim + 32'h1;
          end
        end
      endcase
    end
    // interrupt pin from the two flags
    n.int_n = r.intc[INT_AND] ? ~(r.intc[INT_PFLAG] & r.intc[INT_AFLAG])
                              : ~(r.intc[INT_PFLAG] | r.intc[INT_AFLAG]);
    n.sda_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.scl1 <= 1'b1;
      r.scl2 <= 1'b1;
      r.scl3 <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
      r.sda3 <= 1'b1;
      r.st <= I_IDLE;
      r.pst <= P_OFF;
      r.pht <= RST_PHT;
      r.ats <= RST_ATS;
      r.ahu <= RST_AHU;
      r.int_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign sda_o = r.sda_o;
  assign sda_oe = r.sda_oe;
  assign int_n = r.int_n;
  assign led_sink_pin = r.led;
  assign led_drive_strength = r.led_hi;
  assign ambient_range_select = r.cfg[CFG_RNG];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_hit;
    r.st == I_RX && fall && r.bits == 4'h8 && r.bidx == 2'h0 && r.sh[7:1] == {ADDR_HI, r.ad2};
  endsequence
  sequence s_addr_miss;
    r.st == I_RX && fall && r.bits == 4'h8 && r.bidx == 2'h0 && r.sh[7:1] != {ADDR_HI, r.ad2};
  endsequence

  a_addr_ack: assert property (s_addr_hit |=> r.sda_oe && r.st == I_ACK)
    else $error("matching address not acknowledged");
  a_addr_other: assert property (s_addr_miss |=> !r.sda_oe && r.st == I_IDLE)
    else $error("foreign address acknowledged");
  a_als_period: assert property (r.atim < ALS_PERIOD)
    else $error("ambient timer passed its period");
  a_als_source: assert property (aevt |=> r.ares == ($past(r.cfg[CFG_IRM]) ? $past(r.ai2) : $past(r.av2)))
    else $error("ambient result from wrong source");
  a_aflag_hold: assert property (r.intc[INT_AFLAG] && !(wr && r.ptr == REG_INT && !r.sh[INT_AFLAG])
    |=> r.intc[INT_AFLAG])
    else $error("ambient flag dropped without host clear");
  a_led_window: assert property (r.led |-> r.pst == P_LED && r.ptim <= LED_ON)
    else $error("led on outside its pulse");
  a_led_amp: assert property ($rose(r.led) |-> r.led_hi == $past(r.cfg[CFG_DRV]))
    else $error("led amplitude not from drive bit");
  a_prox_sub: assert property (pstore |=> r.pres == ($past(r.post) > $past(r.pre) ?
    8'($past(r.post) - $past(r.pre)) : 8'h00))
    else $error("proximity result not ambient-cancelled");
  a_pflag_set: assert property (pset |=> r.intc[INT_PFLAG] ##1 1'b1)
    else $error("proximity flag not set");
  a_int_pin: assert property (##1 r.int_n == ($past(r.intc[INT_AND]) ?
    !($past(r.intc[INT_PFLAG]) && $past(r.intc[INT_AFLAG])) :
    !($past(r.intc[INT_PFLAG]) || $past(r.intc[INT_AFLAG]))))
    else $error("interrupt pin does not follow flags");
  a_test_halt: assert property (!normal |=> r.pst == P_OFF && !r.led && r.atim == 32'h0)
    else $error("conversion ran with test registers set");
endmodule // lpr_top

// [tb/lpr_host.sv]
/*
  two-wire bus master model that reaches the readout's registers.
  assumes a pulled-up data line whose level comes back on sda.
*/
`timescale 1ns/1ps
module lpr_host (
  input wire logic core_clk, // paces every bus change
  input wire logic sda, // data line level
  output logic scl, // bus clock, high while idle
  output logic sda_low // high while pulling data low
);
  logic [6:0] dev = 7'h44; // address sent in the first byte

  // idle bus: clock high, data released
  initial {scl, sda_low} = 2'b10;

  // one quarter bit later, set both lines; a bit lasts 120 ns
  task automatic put(input logic c, input logic d);
    repeat (3) @(negedge core_clk);
    scl = c;
    sda_low = d;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
    put(1'b0, 1'b1);
  endtask

  // one bit: data set while low, sampled halfway through the high phase
  task automatic bit_io(input logic b, output logic s);
    put(1'b0, !b);
    put(1'b1, !b);
    repeat (3) @(negedge core_clk);
    s = sda;
    put(1'b0, !b);
  endtask

  // a byte and the ninth bit; ack is the low level seen there
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, s);
    ack = !s;
  endtask

  // write: address, pointer, data; read: address, pointer, restart, one refused byte
  task automatic txn(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r,
                     output logic ok);
    logic k0, k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    if (rd) begin
      start();
      xfer({dev, 1'b1}, 1'b1, r, k2);
      xfer(8'hFF, 1'b1, r, k3);
    end else begin
      xfer(d, 1'b1, r, k2);
    end
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    ok = k0 & k1 & k2;
  endtask
endmodule // lpr_host

// [tb/tb_top.sv]
/*
  self-checking bench of the light/proximity readout.
  assumes the host model lpr_host and shortened conversion counts.
*/
`timescale 1ns/1ps
module tb_top;
  import lpr_pkg::*;
  localparam logic [31:0] AP = 32'd2000;
  localparam logic [31:0] LO = 32'd10;
  localparam logic [31:0] PC = 32'd40;
  localparam logic [31:0] SU = 32'd20;
  localparam int SL [8] = '{64, 32, 16, 8, 6, 4, 1, 0};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic addr_sel = 1'b0;
  logic [7:0] refl = 8'h30;
  logic [7:0] lvl = 8'h20;
  logic [11:0] vis = 12'h123;
  logic scl, sda_low, sda, sda_oe, sdo, int_n, led, drv, rng;
  int err_count = 0, n_compared = 0;
  int pulses = 0, width = 0, gap = 0, tw = 0, tg = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  // pulled-up data line, low while either side pulls
  assign sda = sda_oe ? (sdo & !sda_low) : !sda_low;
  // photodiode: reflection adds to ambient only while the led is on
  always @(negedge core_clk) lvl <= led ? 8'h20 + refl : 8'h20;
  // led pulse count, last width and rise-to-rise spacing
  always @(negedge core_clk) begin
    tg <= tg + 1;
    tw <= led ? tw + 1 : 0;
    if (led === 1'b1 && tw == 0) begin
      pulses <= pulses + 1;
      gap <= tg;
      tg <= 1;
    end
    if (led === 1'b0 && tw != 0) width <= tw;
  end

  lpr_top #(.ALS_PERIOD(AP), .PROX_CONV(PC), .LED_ON(LO), .SLEEP_UNIT(SU)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe(sda_oe),
    .address_select_pin(addr_sel), .als_visible_code(vis), .als_ir_code(12'h456),
    .prox_ir_level(lvl), .int_n(int_n), .led_sink_pin(led), .led_drive_strength(drv),
    .ambient_range_select(rng));
  lpr_host u_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ok;
    logic [7:0] r;
    u_host.txn(1'b0, {4'h0, a}, d, r, ok);
    chk("write ack", 32'd1, 32'(ok));
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] r;
    u_host.txn(1'b1, {4'h0, a}, 8'h00, r, ok);
    chk("read ack", 32'd1, 32'(ok));
    chk($sformatf("reg %0h", a), 32'(e), 32'(r));
  endtask
  task automatic wait_int(input logic v);
    for (int k = 0; k < 2000 && int_n !== v; k++) begin
      @(negedge core_clk);
    end
  endtask
  task automatic wait_p(input int n);
    int p;
    p = pulses;
    for (int k = 0; k < 6000 && pulses - p < n; k++) begin
      @(negedge core_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic ok;
    logic [7:0] r;
    chk("int idle", 32'd1, 32'(int_n));
    for (int i = 0; i < 16; i++) begin
      rdc(4'(i), (i == 4) ? RST_PHT : (i == 7) ? RST_AHU : (i == 6) ? RST_ATS : 8'h00);
    end
    addr_sel = 1'b1;
    u_host.txn(1'b0, 8'h03, 8'h55, r, ok);
    chk("nack other address", 32'd0, 32'(ok));
    u_host.dev = 7'h45;
    rdc(REG_PLT, 8'h00);
    u_host.dev = 7'h44;
    addr_sel = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_prox();
    int p;
    wr(REG_PHT, 8'h28);
    wr(REG_PLT, 8'h10);
    wr(REG_INT, 8'h20);
    p = pulses;
    wr(REG_CFG, 8'hF8);
    wait_int(1'b0);
    chk("trips to set", 32'd4, 32'(pulses - p));
    chk("led width", LO, 32'(width));
    chk("drive high", 32'd1, 32'(drv));
    rdc(REG_PRES, 8'h30);
    rdc(REG_INT, 8'hA0);
    wr(REG_INT, 8'hE0);
    rdc(REG_INT, 8'hE0);
    while (led !== 1'b1) @(negedge core_clk);
    while (led !== 1'b0) @(negedge core_clk);
    refl = 8'h05;
    p = pulses;
    wait_int(1'b1);
    chk("trips to clear", 32'd16, 32'(pulses - p));
    $display("test prox done");
  endtask
  task automatic t_sleep();
    for (int c = 7; c >= 0; c--) begin
      wr(REG_CFG, 8'h80 | 8'(c << 4));
      wait_p(3);
      chk("sleep gap", PC + 32'd1 + 32'(SL[c]) * SU, 32'(gap));
    end
    wr(REG_CFG, 8'h00);
    $display("test sleep done");
  endtask
  task automatic t_als();
    wr(REG_ATS, 8'h00);
    wr(REG_AHU, 8'h10);
    wr(REG_INT, 8'h00);
    wr(REG_CFG, 8'h04);
    repeat (AP + 100) @(negedge core_clk);
    rdc(REG_ARL, 8'h23);
    rdc(REG_ARH, 8'h01);
    chk("int or", 32'd0, 32'(int_n));
    wr(REG_AHU, 8'hFF);
    wr(REG_ATS, 8'hF0);
    repeat (AP + 100) @(negedge core_clk);
    rdc(REG_INT, 8'h08);
    wr(REG_INT, 8'h00);
    rdc(REG_INT, 8'h00);
    wr(REG_CFG, 8'h05);
    wr(REG_ATS, 8'h00);
    wr(REG_AHU, 8'h10);
    wr(REG_INT, 8'h01);
    repeat (2 * AP) @(negedge core_clk);
    rdc(REG_ARL, 8'h56);
    rdc(REG_ARH, 8'h04);
    rdc(REG_INT, 8'h09);
    chk("int and", 32'd1, 32'(int_n));
    vis = 12'h7D1;
    wr(REG_CFG, 8'h04);
    repeat (AP + 100) @(negedge core_clk);
    rdc(REG_ARL, 8'hD1);
    rdc(REG_ARH, 8'h07);
    chk("range low", 32'd0, 32'(rng));
    if (vis > 12'd1800) wr(REG_CFG, 8'h06);
    chk("range high", 32'd1, 32'(rng));
    wr(REG_CFG, 8'h00);
    wr(REG_INT, 8'h00);
    $display("test als done");
  endtask
  task automatic t_test();
    int p;
    wr(REG_CFG, 8'hF0);
    wait_p(2);
    chk("drive low", 32'd0, 32'(drv));
    wr(REG_T2, 8'h01);
    p = pulses;
    repeat (300) @(negedge core_clk);
    chk("halted", 32'd0, 32'(pulses - p));
    wr(REG_T2, 8'h00);
    p = pulses;
    wait_p(1);
    chk("resumed", 32'd1, 32'(pulses - p));
    wr(REG_CFG, 8'h00);
    $display("test mode done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_prox();
    t_sleep();
    t_als();
    t_test();
    test_done();
  end
  // watchdog, about twice the expected run
  initial begin
    #900000;
    err_count++;
    $display("FAIL watchdog expected done seen timeout");
    test_done();
  end
endmodule // tb_top
